// >>> design/iep_regs.svh
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH
// Register indices on the plain port
`define IEP_OFF_ENABLE_1    4'h0
`define IEP_OFF_ENABLE_2    4'h1
`define IEP_OFF_ENABLE_3    4'h2
`define IEP_OFF_ENABLE_4    4'h3
`define IEP_OFF_PRIORITY_0  4'h4
`define IEP_OFF_FLAGS       4'h5
`define IEP_OFF_FLAG_CLEAR  4'h6
`define IEP_OFF_REQUESTS    4'h7
// Implemented-bit masks
`define IEP_MASK_ENABLE_1   16'h000b
`define IEP_MASK_ENABLE_2   16'h000f
`define IEP_MASK_ENABLE_3   16'h1807
`define IEP_MASK_ENABLE_4   16'h0037
`define IEP_MASK_PRIORITY_0 16'h7777
// Reset values
`define IEP_RST_ENABLE      16'h0000
`define IEP_RST_PRIORITY_0  16'h4444
// Enable register 1 fields
`define IEP_BIT_PIN_CHANGE  3
`define IEP_BIT_TWA_MASTER  1
`define IEP_BIT_TWA_SLAVE   0
// Enable register 2 fields
`define IEP_BIT_CANA_EVENT  3
`define IEP_BIT_CANA_RX     2
`define IEP_BIT_SPB_EVENT   1
`define IEP_BIT_SPB_ERROR   0
// Enable register 3 fields
`define IEP_BIT_CODEC_EVENT 12
`define IEP_BIT_CODEC_ERROR 11
`define IEP_BIT_TWB_MASTER  2
`define IEP_BIT_TWB_SLAVE   1
`define IEP_BIT_TIMER7      0
// Enable register 4 fields
`define IEP_BIT_XFER_CH7    5
`define IEP_BIT_XFER_CH6    4
`define IEP_BIT_UARTB_ERR   2
`define IEP_BIT_UARTA_ERR   1
`define IEP_BIT_MOTOR_FLTB  0
// Priority register 0 field low bits
`define IEP_POS_TIMER1      12
`define IEP_POS_OUTCMP1     8
`define IEP_POS_INCAP1      4
`define IEP_POS_EXTIRQ0     0
`endif

// >>> design/iep_pkg.sv
package iep_pkg;
  typedef logic [15:0] iep_word_t;
  typedef logic [2:0]  iep_prio_t;
  typedef logic [3:0]  iep_addr_t;
  // Source index in the flag/request vectors
  typedef enum logic [4:0] {
    IEP_SRC_PIN_CHANGE, IEP_SRC_TWA_MASTER, IEP_SRC_TWA_SLAVE,
    IEP_SRC_CANA_EVENT, IEP_SRC_CANA_RX, IEP_SRC_SPB_EVENT,
    IEP_SRC_SPB_ERROR, IEP_SRC_CODEC_EVENT, IEP_SRC_CODEC_ERROR,
    IEP_SRC_TWB_MASTER, IEP_SRC_TWB_SLAVE, IEP_SRC_TIMER7,
    IEP_SRC_XFER_CH7, IEP_SRC_XFER_CH6, IEP_SRC_UARTB_ERR,
    IEP_SRC_UARTA_ERR, IEP_SRC_MOTOR_FLTB, IEP_SRC_TIMER1,
    IEP_SRC_OUTCMP1, IEP_SRC_INCAP1, IEP_SRC_EXTIRQ0
  } iep_src_t;
  localparam int IEP_NSRC = 21;
  localparam int IEP_NPRIO = 4;
endpackage : iep_pkg

// >>> design/iep_gate_if.sv
`timescale 1ns/1ns
interface iep_gate_if;
  import iep_pkg::*;
  logic [IEP_NSRC-1:0]  flag;
  logic [IEP_NSRC-1:0]  enable;
  logic [IEP_NPRIO-1:0] prio_nonzero;
  logic [IEP_NSRC-1:0]  request;
  logic                 any_request;
  modport regs (output flag, output enable, output prio_nonzero,
                input request, input any_request);
  modport gate (input flag, input enable, input prio_nonzero,
                output request, output any_request);
endinterface : iep_gate_if

// >>> design/iep_gate.sv
`timescale 1ns/1ns
module iep_gate
  import iep_pkg::*;
(
  iep_gate_if.gate g
);
  localparam int NPLAIN = IEP_NSRC - IEP_NPRIO;
  wire [IEP_NSRC-1:0] prio_ok;
  // Sources without a priority field here are assumed to hold a
  // non-zero level elsewhere; only the four below can be disabled
  assign prio_ok = {g.prio_nonzero, {NPLAIN{1'b1}}};
  // Flag and enable and non-zero priority
  assign g.request = g.flag & g.enable & prio_ok;
  assign g.any_request = |g.request;
endmodule : iep_gate

// >>> design/iep_ctrl.sv
`timescale 1ns/1ns
`include "iep_regs.svh"
// Summary of operation
// - Enable bit set lets a pending flagged request go to priority handling.
// - Enable bit clear blocks the request even with its flag set.
// - Unimplemented bits read zero and ignore writes.
// - Priority fields are 3 bits; 111 highest, 001 lowest.
// - Enable bits are read/write and reset to zero.
// - Each priority field resets to binary 100.
// - Priority register 0: timer1 14-12, cmp1 10-8, cap1 6-4, ext0 2-0.
// - Enable 4: channel 7 done bit 5, channel 6 done bit 4.
// - Enable 3: codec event bit 12, codec error bit 11.
// - Enable 1: two-wire A master bit 1, slave bit 0.
// - Enable 1: pin change notification bit 3.
// - Enable 2: CAN A receive ready bit 2, event bit 3.
// - Enable 2: serial B event bit 1, error bit 0.
// - Enable 4: UART B error 2, UART A error 1, motor fault B 0.
// - Enable 3: two-wire B master 2, slave 1, timer 7 bit 0.
// - Request flags of sources 0-15 read one once their event occurred.
module iep_ctrl
  import iep_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire iep_addr_t           addr,
  input  wire iep_word_t           wdata,
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  output iep_word_t                rdata,
  input  wire logic [IEP_NSRC-1:0] src_event,
  output logic [IEP_NSRC-1:0]      src_request,
  output logic                     cpu_request,
  output iep_prio_t                cpu_priority
);
  iep_gate_if gi ();

  iep_word_t           en1_r, en2_r, en3_r, en4_r, prio0_r;
  iep_word_t           rdata_r;
  logic [IEP_NSRC-1:0] flag_r;
  logic [IEP_NSRC-1:0] flag_nxt;
  logic [IEP_NSRC-1:0] clr_vec;
  logic [IEP_NSRC-1:0] req_r;
  iep_prio_t           prio_r;
  iep_word_t           rd_mux;

  // Pull one field out of the priority word
  function automatic iep_prio_t prio_field(iep_word_t w, int pos);
    prio_field = w[pos +: 3];
  endfunction : prio_field

  // Pick the higher of two priority codes
  function automatic iep_prio_t prio_max(iep_prio_t a, iep_prio_t b);
    prio_max = (a > b) ? a : b;
  endfunction : prio_max

  wire wr_en1   = wr_stb && (addr == `IEP_OFF_ENABLE_1);
  wire wr_en2   = wr_stb && (addr == `IEP_OFF_ENABLE_2);
  wire wr_en3   = wr_stb && (addr == `IEP_OFF_ENABLE_3);
  wire wr_en4   = wr_stb && (addr == `IEP_OFF_ENABLE_4);
  wire wr_prio0 = wr_stb && (addr == `IEP_OFF_PRIORITY_0);
  wire wr_flclr = wr_stb && (addr == `IEP_OFF_FLAG_CLEAR);

  wire iep_prio_t p_t1  = prio_field(prio0_r, `IEP_POS_TIMER1);
  wire iep_prio_t p_oc1 = prio_field(prio0_r, `IEP_POS_OUTCMP1);
  wire iep_prio_t p_ic1 = prio_field(prio0_r, `IEP_POS_INCAP1);
  wire iep_prio_t p_ex0 = prio_field(prio0_r, `IEP_POS_EXTIRQ0);

  // Enable vector in source order
  wire [IEP_NSRC-1:0] en_vec = {
    1'b1, 1'b1, 1'b1, 1'b1,
    en4_r[`IEP_BIT_MOTOR_FLTB],
    en4_r[`IEP_BIT_UARTA_ERR],
    en4_r[`IEP_BIT_UARTB_ERR],
    en4_r[`IEP_BIT_XFER_CH6],
    en4_r[`IEP_BIT_XFER_CH7],
    en3_r[`IEP_BIT_TIMER7],
    en3_r[`IEP_BIT_TWB_SLAVE],
    en3_r[`IEP_BIT_TWB_MASTER],
    en3_r[`IEP_BIT_CODEC_ERROR],
    en3_r[`IEP_BIT_CODEC_EVENT],
    en2_r[`IEP_BIT_SPB_ERROR],
    en2_r[`IEP_BIT_SPB_EVENT],
    en2_r[`IEP_BIT_CANA_RX],
    en2_r[`IEP_BIT_CANA_EVENT],
    en1_r[`IEP_BIT_TWA_SLAVE],
    en1_r[`IEP_BIT_TWA_MASTER],
    en1_r[`IEP_BIT_PIN_CHANGE]
  };

  // Priority-0 sources have no enable bit in this block's registers;
  // their gating is left to the priority field alone
  assign gi.enable = en_vec;
  assign gi.flag = flag_r;
  assign gi.prio_nonzero = {p_ex0 != 3'h0, p_ic1 != 3'h0,
                            p_oc1 != 3'h0, p_t1 != 3'h0};

  iep_gate u_gate (
    .g (gi.gate)
  );

  // Clear word is one bus word wide: only the low 16 flags clear
  assign clr_vec = wr_flclr ? {{(IEP_NSRC-16){1'b0}}, wdata} : '0;
  // New event beats a simultaneous clear
  assign flag_nxt = (flag_r & ~clr_vec) | src_event;

  // Highest priority among live prioritised sources
  wire iep_prio_t pr_a = prio_max(
    gi.request[IEP_SRC_TIMER1]  ? p_t1  : 3'h0,
    gi.request[IEP_SRC_OUTCMP1] ? p_oc1 : 3'h0);
  wire iep_prio_t pr_b = prio_max(
    gi.request[IEP_SRC_INCAP1]  ? p_ic1 : 3'h0,
    gi.request[IEP_SRC_EXTIRQ0] ? p_ex0 : 3'h0);
  wire iep_prio_t pr_sel = prio_max(pr_a, pr_b);

  always_comb
  begin
    unique case (addr)
      `IEP_OFF_ENABLE_1:   rd_mux = en1_r;
      `IEP_OFF_ENABLE_2:   rd_mux = en2_r;
      `IEP_OFF_ENABLE_3:   rd_mux = en3_r;
      `IEP_OFF_ENABLE_4:   rd_mux = en4_r;
      `IEP_OFF_PRIORITY_0: rd_mux = prio0_r;
      `IEP_OFF_FLAGS:      rd_mux = flag_r[15:0];
      `IEP_OFF_REQUESTS:   rd_mux = req_r[15:0];
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      en1_r   <= `IEP_RST_ENABLE;
      en2_r   <= `IEP_RST_ENABLE;
      en3_r   <= `IEP_RST_ENABLE;
      en4_r   <= `IEP_RST_ENABLE;
      prio0_r <= `IEP_RST_PRIORITY_0;
    end
    else
    begin
      // Masks keep unimplemented bits at zero
      if (wr_en1)
        en1_r <= wdata & `IEP_MASK_ENABLE_1;
      if (wr_en2)
        en2_r <= wdata & `IEP_MASK_ENABLE_2;
      if (wr_en3)
        en3_r <= wdata & `IEP_MASK_ENABLE_3;
      if (wr_en4)
        en4_r <= wdata & `IEP_MASK_ENABLE_4;
      if (wr_prio0)
        prio0_r <= wdata & `IEP_MASK_PRIORITY_0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      flag_r  <= '0;
      req_r   <= '0;
      prio_r  <= 3'h0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      flag_r  <= flag_nxt;
      req_r   <= gi.request;
      prio_r  <= pr_sel;
      rdata_r <= rd_stb ? rd_mux : 16'h0000;
    end
  end

  assign rdata        = rdata_r;
  assign src_request  = req_r;
  assign cpu_request  = |req_r;
  assign cpu_priority = prio_r;
endmodule : iep_ctrl

// >>> verif/iep_cpu_model.sv
`timescale 1ns/1ns
module iep_cpu_model
  import iep_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      cpu_request,
  input  wire iep_prio_t cpu_priority,
  output iep_prio_t      taken_prio
);
  // Core keeps the last level it was asked to serve
  always_ff @(posedge clk)
    if (!reset_n)
      taken_prio <= 3'h0;
    else if (cpu_request)
      taken_prio <= cpu_priority;
endmodule : iep_cpu_model

// >>> verif/iep_ctrl_chk.sv
`timescale 1ns/1ns
module iep_ctrl_chk
  import iep_pkg::*;
(
  input wire logic                clk,
  input wire logic                reset_n,
  input wire iep_addr_t           addr,
  input wire iep_word_t           wdata,
  input wire logic                wr_stb,
  input wire logic                rd_stb,
  input wire iep_word_t           rdata,
  input wire logic [IEP_NSRC-1:0] src_request,
  input wire logic                cpu_request,
  input wire iep_prio_t           cpu_priority
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rd_idle_zero_a: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data not zero");
  unmapped_zero_a: assert property (rd_stb && addr[3] |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  prio_mask_a: assert property (rd_stb && addr == 4'h4 |=>
    (rdata & 16'h8888) == 16'h0000) else $error("priority gap bit set");
  cpu_or_a: assert property (cpu_request == (src_request != '0))
    else $error("cpu request differs");
  prio_level_a: assert property ((cpu_priority != 3'h0) ==
    (src_request[20:17] != 4'h0)) else $error("priority level wrong");
  wr_back_a: assert property (wr_stb && addr == 4'h1 ##1 rd_stb &&
    addr == 4'h1 |=> rdata == ($past(wdata, 2) & 16'h000f))
    else $error("enable readback wrong");
  en_off_a: assert property (wr_stb && addr == 4'h0 && !wdata[3]
    |-> ##2 !src_request[0]) else $error("disabled source requests");
  prio_off_a: assert property (wr_stb && addr == 4'h4 &&
    wdata[14:12] == 3'h0 |-> ##2 !src_request[17])
    else $error("priority zero source requests");
endmodule : iep_ctrl_chk
bind iep_ctrl iep_ctrl_chk u_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .src_request(src_request), .cpu_request(cpu_request),
  .cpu_priority(cpu_priority));

// >>> verif/iep_ctrl_tb.sv
`timescale 1ns/1ns
module iep_ctrl_tb;
  import iep_pkg::*;
  logic clk, reset_n, wr_stb, rd_stb, cpu_request;
  logic [IEP_NSRC-1:0] src_event, src_request;
  iep_addr_t addr, a;
  iep_word_t wdata, rdata, d, e;
  iep_prio_t cpu_priority, taken_prio;
  int bad_count, check_count, i;
  iep_word_t msk[5] = '{16'h000b, 16'h000f, 16'h1807, 16'h0037, 16'h7777};
  // Register index in the high nibble, bit in the low one
  byte unsigned loc[17] = '{8'h03, 8'h01, 8'h00,
    8'h13, 8'h12, 8'h11, 8'h10, 8'h2c, 8'h2b,
    8'h22, 8'h21, 8'h20, 8'h35, 8'h34,
    8'h32, 8'h31, 8'h30};
  iep_ctrl dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .src_event(src_event),
    .src_request(src_request), .cpu_request(cpu_request),
    .cpu_priority(cpu_priority));
  iep_cpu_model cpu (.clk(clk), .reset_n(reset_n), .cpu_request(cpu_request),
    .cpu_priority(cpu_priority), .taken_prio(taken_prio));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input iep_addr_t ad, input iep_word_t v);
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    addr <= ad;
    wdata <= v;
    @(posedge clk);
  endtask : wr
  task rd(input iep_addr_t ad, output iep_word_t v);
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    addr <= ad;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask : rd
  task idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    src_event <= '0;
    repeat (n) @(posedge clk);
  endtask : idle
  task ev(input logic [IEP_NSRC-1:0] m);
    src_event <= m;
    wr_stb <= 1'b0;
    @(posedge clk);
    idle(3);
  endtask : ev
  function automatic iep_prio_t pmax(input iep_word_t v);
    pmax = 3'h0;
    for (int k = 0; k < 16; k += 4)
      if (v[k+:3] > pmax)
        pmax = v[k+:3];
  endfunction : pmax
  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial
  begin
    #2000000;
    bad_count++;
    conclude();
  end
  initial
  begin
    {reset_n, wr_stb, rd_stb, addr, wdata, src_event} = '0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'heeb7));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i++)
    begin
      rd(i[3:0], d);
      chk(d, i == 4 ? 16'h4444 : 16'h0);
    end
    $display("reset values done");
    for (i = 0; i < 40; i++)
    begin
      a = iep_addr_t'(i < 10 ? i % 5 : $urandom_range(15, 0));
      e = iep_word_t'($urandom);
      wr(a, e);
      rd(a, d);
      chk(d, a < 5 ? e & msk[a] : 16'h0);
    end
    for (i = 0; i < 5; i++)
      wr(i[3:0], i == 4 ? 16'h4444 : 16'h0);
    idle(3);
    $display("register access done");
    for (i = 0; i < 17; i++)
    begin
      ev(21'h1 << i);
      chk(src_request, 21'h0);
      wr({2'b00, loc[i][5:4]}, 16'h1 << loc[i][3:0]);
      idle(3);
      chk(src_request, 21'h1 << i);
      chk(cpu_request, 1'b1);
      wr({2'b00, loc[i][5:4]}, 16'h0);
      idle(3);
      chk(src_request, 21'h0);
    end
    $display("enable gating done");
    rd(4'h5, d);
    chk(d, 16'hffff);
    src_event <= 21'h1;
    wr(4'h6, 16'hffff);
    idle(1);
    rd(4'h5, d);
    chk(d, 16'h0001);
    wr(4'h0, 16'h0008);
    idle(2);
    rd(4'h7, d);
    chk(d, 16'h0001);
    wr(4'h0, 16'h0000);
    $display("flag access done");
    ev(21'h1e0000);
    chk(cpu_priority, 3'h4);
    for (i = 0; i < 24; i++)
    begin
      e = i == 0 ? 16'h0 : i == 1 ? 16'h7777 : iep_word_t'($urandom);
      wr(4'h4, e);
      idle(3);
      chk(src_request[20:17], {e[2:0] != 0, e[6:4] != 0,
        e[10:8] != 0, e[14:12] != 0});
      chk(cpu_priority, pmax(e));
      if (pmax(e) != 3'h0)
        chk(taken_prio, pmax(e));
    end
    $display("priority done");
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(src_request, 21'h0);
    for (i = 0; i < 8; i++)
    begin
      rd(i[3:0], d);
      chk(d, i == 4 ? 16'h4444 : 16'h0);
    end
    $display("second reset done");
    conclude();
  end
endmodule : iep_ctrl_tb
